// *** src/lmfcs_align_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Subclass 1 uses reference rise, else internal
// - Reference rising edges sampled on clk_sys
// - Sampling phase stored as 12-bit thermometer
// - Any periodic reference pattern works unchanged
// - Every mode phase-checks each alignment edge
// - One-shot aligns first edge, then monitors
// - Continuous checks every edge, realigns edges outside window
// - Monitor reports error, never adjusts phase
// - Monitor edge snapshots phase, sets jitter flag if outside window
// - Six-bit window, low two bits ignored
// - Any pulse counter write clears count
// - Status-low write captures status and count
// - Status value spans high and low registers
// - Thermometer phase shows in low upper nibble
// - Dynamic link latency readable for delay setup
module lmfcs_align_sync (
   input  wire logic                     clk_sys,
   input  wire logic                     reset_n,
   input  wire lmfcs_pkg::lmfcs_reg_req_t reg_req,
   output logic                   [7:0]  reg_rdata,
   input  wire logic                     ref_in,
   input  wire logic              [11:0] ref_phase_therm,
   input  wire logic                     data_start,
   input  wire logic                     jitter_irq_clear,
   output logic                          edge_jitter_interrupt,
   output logic                          link_enable,
   output logic                   [7:0]  lmfc_delay,
   output logic                   [7:0]  lmfc_variable,
   output logic                   [15:0] lmfc_phase
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   localparam logic [15:0] PERIOD = 16'(lmfcs_pkg::LMFC_DAC_CLKS);
   localparam logic [5:0]  SC0_LAST = 6'(lmfcs_pkg::SC0_EDGE_CLKS - 1);

   // Distance of a phase from the nearest multiframe boundary
   function automatic logic [15:0] phase_dev(input logic [15:0] ph);
      logic [15:0] back;
      back = PERIOD - ph;
      return (ph <= back) ? ph : back;
   endfunction

   // Write strobe for one offset
   function automatic logic wr_hit(input logic [11:0] ofs);
      return reg_req.wr && (reg_req.addr == ofs);
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0]  win_reg;         // Edge tolerance window
   logic [1:0]  mode_reg;        // Align mode field
   logic [2:0]  subclass_reg;    // Subclass field
   logic        armed_reg;       // One-shot waits for an edge
   logic [7:0]  pulse_cnt_reg;   // Running reference pulse counter
   logic [7:0]  pulse_hold_reg;  // Captured pulse count
   logic [15:0] status_reg;      // Last measured status value
   logic [15:0] status_hold_reg; // Captured status value
   logic [11:0] phase_reg;       // Reference sample phase
   logic [7:0]  latency_reg;     // Dynamic link latency
   logic        ref_prev_reg;    // Previous reference sample
   logic [5:0]  sc0_cnt_reg;     // Internal edge divider
   logic [7:0]  reg_rdata_next;  // Read mux result

   // ------------------------------------------------------------
   // Edge detection and alignment decision
   // ------------------------------------------------------------
   wire         sub1       = (subclass_reg == lmfcs_pkg::SUBCLASS_1);
   wire         ref_rise   = ref_in && !ref_prev_reg;
   wire         int_edge   = (sc0_cnt_reg == SC0_LAST);
   wire         align_edge = sub1 ? ref_rise : int_edge;
   wire [15:0]  deviation  = phase_dev(lmfc_phase);
   wire [3:0]   win_steps  = win_reg[lmfcs_pkg::WIN_MSB:lmfcs_pkg::WIN_IGN_BITS];
   wire [15:0]  tolerance  = {10'h000, win_steps, 2'h0};
   // Window zero means zero tolerance: any nonzero error violates
   wire         violation  = align_edge && (deviation > tolerance);
   wire         may_adjust = (mode_reg == lmfcs_pkg::LMFCS_MODE_CONT) ||
                             ((mode_reg == lmfcs_pkg::LMFCS_MODE_ONESHOT) && armed_reg);
   wire         align_now  = violation && may_adjust;
   wire         oneshot_done = align_edge && armed_reg &&
                             (mode_reg == lmfcs_pkg::LMFCS_MODE_ONESHOT);

   // ------------------------------------------------------------
   // Write decodes
   // ------------------------------------------------------------
   wire         wr_mode    = wr_hit(lmfcs_pkg::OFS_SYNC_MODE);
   wire         wr_win     = wr_hit(lmfcs_pkg::OFS_JIT_WIN);
   wire         wr_cnt     = wr_hit(lmfcs_pkg::OFS_PULSE_CNT);
   wire         wr_stat    = wr_hit(lmfcs_pkg::OFS_STAT_LOW);
   wire         wr_link    = wr_hit(lmfcs_pkg::OFS_LINK_CTRL);
   wire         wr_del     = wr_hit(lmfcs_pkg::OFS_LMFC_DEL);
   wire         wr_var     = wr_hit(lmfcs_pkg::OFS_LMFC_VAR);
   wire         wr_sub     = wr_hit(lmfcs_pkg::OFS_SUBCLASS);
   wire [1:0]   mode_wdata = reg_req.wdata[lmfcs_pkg::MODE_LSB +: 2];
   wire         arm_req    = wr_mode &&
                             (mode_wdata == lmfcs_pkg::LMFCS_MODE_ONESHOT);

   // ------------------------------------------------------------
   // Multiframe phase counter
   // ------------------------------------------------------------
   lmfcs_lmfc_counter u_counter (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .align_now  (align_now),
      .lmfc_count (lmfc_phase)
   );

   // ------------------------------------------------------------
   // Edge sampling and internal edge divider
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ref_prev_reg <= 1'b0;
         sc0_cnt_reg  <= 6'h00;
      end else begin
         ref_prev_reg <= ref_in;
         sc0_cnt_reg  <= int_edge ? 6'h00 : sc0_cnt_reg + 6'h01;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         win_reg       <= lmfcs_pkg::RST_BYTE;
         subclass_reg  <= 3'h0;
         link_enable   <= 1'b0;
         lmfc_delay    <= lmfcs_pkg::RST_BYTE;
         lmfc_variable <= lmfcs_pkg::RST_BYTE;
      end else begin
         // Window upper bits dropped, stored and read back as zero
         if (wr_win) begin
            win_reg <= {2'h0, reg_req.wdata[lmfcs_pkg::WIN_MSB:0]};
         end
         if (wr_sub) begin
            subclass_reg <= reg_req.wdata[lmfcs_pkg::SUBCL_LSB +: 3];
         end
         // Link enable driven by software
         if (wr_link) begin
            link_enable <= reg_req.wdata[lmfcs_pkg::LINK_EN_BIT];
         end
         // Delay settings taken after latency readback
         if (wr_del) begin
            lmfc_delay <= reg_req.wdata;
         end
         if (wr_var) begin
            lmfc_variable <= reg_req.wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Mode and arming
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg  <= lmfcs_pkg::LMFCS_MODE_MONITOR;
         armed_reg <= 1'b0;
      end else if (oneshot_done) begin
         // One-shot falls back to monitor after its edge
         mode_reg  <= lmfcs_pkg::LMFCS_MODE_MONITOR;
         armed_reg <= 1'b0;
      end else if (wr_mode) begin
         // Writing two arms; continuous needs no arming
         mode_reg  <= mode_wdata;
         armed_reg <= arm_req;
      end
   end

   // ------------------------------------------------------------
   // Measurement captures
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= lmfcs_pkg::RST_STATUS;
         phase_reg  <= lmfcs_pkg::RST_PHASE;
      end else if (align_edge) begin
         // Snapshot the LMFC count and sampling phase at each edge
         status_reg <= lmfc_phase;
         phase_reg  <= ref_phase_therm;
      end
   end

   // ------------------------------------------------------------
   // Pulse counter and status holding registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pulse_cnt_reg   <= lmfcs_pkg::RST_BYTE;
         pulse_hold_reg  <= lmfcs_pkg::RST_BYTE;
         status_hold_reg <= lmfcs_pkg::RST_STATUS;
      end else begin
         // Clear wins over a pulse in the same cycle
         if (wr_cnt) begin
            pulse_cnt_reg <= lmfcs_pkg::RST_BYTE;
         end else if (align_edge && sub1) begin
            pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
         end
         // Capture for readback
         if (wr_stat) begin
            pulse_hold_reg  <= pulse_cnt_reg;
            status_hold_reg <= status_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // Jitter flag and link latency
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         edge_jitter_interrupt <= 1'b0;
         latency_reg           <= lmfcs_pkg::RST_BYTE;
      end else begin
         // Set wins over clear
         if (violation) begin
            edge_jitter_interrupt <= 1'b1;
         end else if (jitter_irq_clear) begin
            edge_jitter_interrupt <= 1'b0;
         end
         // Multiframe position when data begins, in clk cycles
         if (data_start) begin
            latency_reg <= 8'(lmfc_phase >> 2);
         end
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      reg_rdata_next = 8'h00;
      unique case (reg_req.addr)
         lmfcs_pkg::OFS_STAT_LOW:   reg_rdata_next = status_hold_reg[7:0];
         lmfcs_pkg::OFS_STAT_HIGH:  reg_rdata_next = status_hold_reg[15:8];
         lmfcs_pkg::OFS_PULSE_CNT:  reg_rdata_next = pulse_hold_reg;
         lmfcs_pkg::OFS_PHASE_LOW:  reg_rdata_next = phase_reg[7:0];
         lmfcs_pkg::OFS_PHASE_HIGH: reg_rdata_next =
            {4'h0, phase_reg[11:12-lmfcs_pkg::PH_HIGH_BITS]};
         lmfcs_pkg::OFS_JIT_WIN:    reg_rdata_next = win_reg;
         lmfcs_pkg::OFS_SYNC_MODE:  reg_rdata_next = {6'h00, mode_reg};
         lmfcs_pkg::OFS_LINK_CTRL:  reg_rdata_next = {7'h00, link_enable};
         lmfcs_pkg::OFS_LINK_LAT:   reg_rdata_next = latency_reg;
         lmfcs_pkg::OFS_LMFC_DEL:   reg_rdata_next = lmfc_delay;
         lmfcs_pkg::OFS_LMFC_VAR:   reg_rdata_next = lmfc_variable;
         lmfcs_pkg::OFS_SUBCLASS:   reg_rdata_next = {subclass_reg, 5'h00};
         default:                   reg_rdata_next = 8'h00;
      endcase
   end

   // Read data registered one cycle after the strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= lmfcs_pkg::RST_BYTE;
      end else if (reg_req.rd) begin
         reg_rdata <= reg_rdata_next;
      end
   end

endmodule

`default_nettype wire

// *** src/lmfcs_pkg.sv ***
package lmfcs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_STAT_LOW   = 12'h034;
   localparam logic [11:0] OFS_STAT_HIGH  = 12'h035;
   localparam logic [11:0] OFS_PULSE_CNT  = 12'h036;
   localparam logic [11:0] OFS_PHASE_LOW  = 12'h037;
   localparam logic [11:0] OFS_PHASE_HIGH = 12'h038;
   localparam logic [11:0] OFS_JIT_WIN    = 12'h039;
   localparam logic [11:0] OFS_SYNC_MODE  = 12'h03A;
   localparam logic [11:0] OFS_LINK_CTRL  = 12'h300;
   localparam logic [11:0] OFS_LINK_LAT   = 12'h302;
   localparam logic [11:0] OFS_LMFC_DEL   = 12'h304;
   localparam logic [11:0] OFS_LMFC_VAR   = 12'h306;
   localparam logic [11:0] OFS_SUBCLASS   = 12'h458;

   // ------------------------------------------------------------
   // Field positions and codes
   // ------------------------------------------------------------
   localparam int          MODE_LSB       = 0;    // Mode field [1:0]
   localparam int          WIN_MSB        = 5;    // Window field [5:0]
   localparam int          WIN_IGN_BITS   = 2;    // Ignored low bits
   localparam int          LINK_EN_BIT    = 0;    // Link enable bit
   localparam int          SUBCL_LSB      = 5;    // Subclass [7:5]
   localparam int          PH_HIGH_BITS   = 4;    // Upper phase bits
   localparam logic [2:0]  SUBCLASS_1     = 3'h1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [11:0] RST_PHASE      = 12'h000;
   localparam logic [15:0] RST_STATUS     = 16'h0000;

   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   localparam int          DAC_PER_CLK    = 4;    // DAC clocks per clk
   localparam int          LMFC_DAC_CLKS  = 128;  // LMFC period, DAC clocks
   localparam int          SC0_EDGE_CLKS  = 32;   // Internal edge period

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LMFCS_MODE_MONITOR = 2'h0,
      LMFCS_MODE_CONT    = 2'h1,
      LMFCS_MODE_ONESHOT = 2'h2
   } lmfcs_mode_t;

   typedef struct packed {
      logic [11:0] addr;   // Register offset
      logic        wr;     // Write strobe, one cycle
      logic        rd;     // Read strobe, one cycle
      logic [7:0]  wdata;  // Write data
   } lmfcs_reg_req_t;

endpackage

// *** src/lmfcs_lmfc_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

// Local multiframe counter in DAC clocks, advanced per clk
module lmfcs_lmfc_counter (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        align_now,
   output logic      [15:0] lmfc_count
);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   localparam logic [15:0] STEP = 16'(lmfcs_pkg::DAC_PER_CLK);
   localparam logic [15:0] LAST =
      16'(lmfcs_pkg::LMFC_DAC_CLKS - lmfcs_pkg::DAC_PER_CLK);

   logic [15:0] count_next;  // Following count

   // Realign loads one step, so the next periodic edge lands on zero
   assign count_next = align_now            ? STEP :
                       (lmfc_count == LAST) ? 16'h0000 :
                       lmfc_count + STEP;

   // Phase reloads one STEP on an alignment, zero on reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lmfc_count <= 16'h0000;
      end else begin
         lmfc_count <= count_next;
      end
   end

endmodule

`default_nettype wire

// *** testbench/lmfcs_align_sync_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the alignment block
module lmfcs_align_sync_props (
   input wire logic                      clk_sys,
   input wire logic                      reset_n,
   input wire lmfcs_pkg::lmfcs_reg_req_t reg_req,
   input wire logic               [7:0]  reg_rdata,
   input wire logic                      ref_in,
   input wire logic               [11:0] ref_phase_therm,
   input wire logic                      data_start,
   input wire logic                      jitter_irq_clear,
   input wire logic                      edge_jitter_interrupt,
   input wire logic                      link_enable,
   input wire logic               [7:0]  lmfc_delay,
   input wire logic               [7:0]  lmfc_variable,
   input wire logic               [15:0] lmfc_phase
);
   // ---
   // Shadows of written settings
   // ---
   logic [1:0]  mode_reg;  // Last mode written
   logic        sc1_reg;   // Subclass 1 chosen
   logic [5:0]  win_reg;   // Window field
   logic [15:0] tol;       // Tolerance in DAC clocks
   logic [15:0] dev;       // Distance to LMFC boundary
   assign tol = {10'h000, win_reg[5:2], 2'h0};
   assign dev = (lmfc_phase > 16'h0040) ? (16'h0080 - lmfc_phase) : lmfc_phase;

   // Follow register writes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= 2'h0;
         sc1_reg  <= 1'b0;
         win_reg  <= 6'h00;
      end else if (reg_req.wr) begin
         if (reg_req.addr == 12'h03A) mode_reg <= reg_req.wdata[1:0];
         if (reg_req.addr == 12'h458) sc1_reg <= (reg_req.wdata[7:5] == 3'h1);
         if (reg_req.addr == 12'h039) win_reg <= reg_req.wdata[5:0];
      end
   end

   // ---
   // Properties
   // ---
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   property p_phase_step;
      $past(reset_n) && lmfc_phase != 16'h0004
         |-> lmfc_phase == (($past(lmfc_phase) + 16'h0004) & 16'h007F);
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("LMFC count step wrong");
   property p_cont_realign;
      mode_reg == 2'h1 && sc1_reg && $rose(ref_in) && dev > tol |=> lmfc_phase == 16'h0004;
   endproperty
   a_cont_realign: assert property (p_cont_realign) else $error("No realign");
   property p_cont_keep;
      mode_reg == 2'h1 && sc1_reg && $rose(ref_in) && dev <= tol && lmfc_phase != 16'h007C
         |=> lmfc_phase == $past(lmfc_phase) + 16'h0004;
   endproperty
   a_cont_keep: assert property (p_cont_keep) else $error("Realign inside window");
   property p_flag_set;
      sc1_reg && $rose(ref_in) && dev > tol |=> edge_jitter_interrupt;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("Jitter flag not set");
   property p_flag_sticky;
      edge_jitter_interrupt && !jitter_irq_clear |=> edge_jitter_interrupt;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("Jitter flag lost");
   property p_monitor_hold;
      mode_reg == 2'h0 && lmfc_phase != 16'h007C
         |=> lmfc_phase == $past(lmfc_phase) + 16'h0004;
   endproperty
   a_monitor_hold: assert property (p_monitor_hold) else $error("Monitor adjusted");
   property p_link_wr;
      reg_req.wr && reg_req.addr == 12'h300
         |=> {7'h00, link_enable} == ($past(reg_req.wdata) & 8'h01);
   endproperty
   a_link_wr: assert property (p_link_wr) else $error("Link enable not written");
   property p_del_wr;
      reg_req.wr && reg_req.addr == 12'h304 |=> lmfc_delay == $past(reg_req.wdata);
   endproperty
   a_del_wr: assert property (p_del_wr) else $error("Delay not written");
   property p_rdata_hold;
      !reg_req.rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved");

   // Main scenarios reached
   c_realign: cover property (mode_reg == 2'h1 && sc1_reg && $rose(ref_in) && dev > tol);
   c_flag: cover property ($rose(edge_jitter_interrupt));
   c_link: cover property ($rose(link_enable));
endmodule

bind lmfcs_align_sync lmfcs_align_sync_props u_props (
   .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .ref_in(ref_in), .ref_phase_therm(ref_phase_therm), .data_start(data_start),
   .jitter_irq_clear(jitter_irq_clear), .edge_jitter_interrupt(edge_jitter_interrupt),
   .link_enable(link_enable), .lmfc_delay(lmfc_delay), .lmfc_variable(lmfc_variable),
   .lmfc_phase(lmfc_phase)
);
`default_nettype wire

// *** testbench/lmfcs_ref_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// Reference source and transmitter stand-in
module lmfcs_ref_source #(
   parameter logic [11:0] THERM = 12'h0F0  // Sampler phase code
) (
   output logic        ref_in,
   output logic [11:0] ref_phase_therm,
   output logic        data_start,
   input  wire logic   clk_sys
);
   // Idle low between pulses
   initial begin
      ref_in = 1'b0;
      data_start = 1'b0;
   end
   assign ref_phase_therm = THERM;

   // One reference pulse, repeated back-to-back only in pulse-count and subclass 0 tests
   task automatic pulse();
      @(posedge clk_sys);
      ref_in <= 1'b1;
      @(posedge clk_sys);
      ref_in <= 1'b0;
   endtask

   // First data after lane alignment
   task automatic start_data();
      @(posedge clk_sys);
      data_start <= 1'b1;
      @(posedge clk_sys);
      data_start <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** testbench/lmfc_alignment_sync_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the alignment block
module lmfc_alignment_sync_bench;
   // ---
   // Signals
   // ---
   logic                      clk_sys = 1'b0;
   logic                      reset_n = 1'b0;
   lmfcs_pkg::lmfcs_reg_req_t reg_req = '0;
   logic                      jitter_irq_clear = 1'b0;
   logic               [7:0]  reg_rdata;
   logic                      ref_in;
   logic               [11:0] ref_phase_therm;
   logic                      data_start;
   logic                      edge_jitter_interrupt;
   logic                      link_enable;
   logic               [15:0] lmfc_phase;
   int                        failures = 0;
   int                        n_checks = 0;
   localparam logic [11:0]    THERM = 12'h0F0;

   always #20 clk_sys = ~clk_sys;

   lmfcs_align_sync DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .ref_in(ref_in), .ref_phase_therm(ref_phase_therm), .data_start(data_start),
      .jitter_irq_clear(jitter_irq_clear), .edge_jitter_interrupt(edge_jitter_interrupt),
      .link_enable(link_enable), .lmfc_delay(), .lmfc_variable(), .lmfc_phase(lmfc_phase)
   );
   lmfcs_ref_source #(.THERM(THERM)) u_source (
      .ref_in(ref_in), .ref_phase_therm(ref_phase_therm), .data_start(data_start),
      .clk_sys(clk_sys)
   );

   // ---
   // Shared tasks
   // ---
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // Reference rise seen while LMFC count is p
   task automatic edge_at(input logic [15:0] p);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (lmfc_phase !== ((p - 16'h0004) & 16'h007F) && n < 300);
      u_source.pulse();
      #1;
   endtask
   task automatic clr_flag();
      @(posedge clk_sys);
      jitter_irq_clear <= 1'b1;
      @(posedge clk_sys);
      jitter_irq_clear <= 1'b0;
      #1 check({15'h0, edge_jitter_interrupt}, 16'h0000);
   endtask

   // ---
   // Scenarios
   // ---
   task automatic test_registers();
      logic [11:0] adr [5] = '{12'h039, 12'h304, 12'h306, 12'h037, 12'h0FF};
      logic [7:0]  wd [5] = '{8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hFF};
      logic [7:0]  ex [5] = '{8'h3F, 8'hA5, 8'h5A, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         rd_chk(adr[i], 8'h00);
         reg_wr(adr[i], wd[i]);
         rd_chk(adr[i], ex[i]);
      end
      reg_wr(12'h039, 8'h00);
   endtask
   task automatic test_pulse_count();
      reg_wr(12'h458, 8'h20);
      reg_wr(12'h036, 8'h5C);
      repeat (2) u_source.pulse();
      edge_at(16'h0020);
      check(lmfc_phase, 16'h0024);
      check({15'h0, edge_jitter_interrupt}, 16'h0001);
      reg_wr(12'h034, 8'h00);
      rd_chk(12'h036, 8'h03);
      rd_chk(12'h034, 8'h20);
      rd_chk(12'h038, {4'h0, THERM[11:8]});
      reg_wr(12'h036, 8'hFF);
      reg_wr(12'h034, 8'h00);
      rd_chk(12'h036, 8'h00);
   endtask
   task automatic test_one_shot();
      reg_wr(12'h039, 8'h04);
      reg_wr(12'h03A, 8'h00);
      reg_wr(12'h03A, 8'h02);
      edge_at(16'h0040);
      check(lmfc_phase, 16'h0004);
      reg_wr(12'h034, 8'h00);
      rd_chk(12'h034, 8'h40);
      rd_chk(12'h035, 8'h00);
      rd_chk(12'h03A, 8'h00);
      rd_chk(12'h037, THERM[7:0]);
      edge_at(16'h0040);
      check(lmfc_phase, 16'h0044);
      reg_wr(12'h300, 8'h01);
      rd_chk(12'h300, 8'h01);
   endtask
   task automatic test_continuous();
      logic [15:0] ph [4] = '{16'h001C, 16'h007C, 16'h0020, 16'h0040};
      logic [15:0] nx [4] = '{16'h0020, 16'h0000, 16'h0004, 16'h0004};
      logic [15:0] fl [4] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001};
      reg_wr(12'h039, 8'h1F);
      reg_wr(12'h03A, 8'h01);
      clr_flag();
      for (int i = 0; i < 4; i++) begin
         edge_at(ph[i]);
         check(lmfc_phase, nx[i]);
         check({15'h0, edge_jitter_interrupt}, fl[i]);
      end
   endtask
   task automatic test_subclass0();
      reg_wr(12'h458, 8'h00);
      reg_wr(12'h039, 8'h00);
      reg_wr(12'h036, 8'h00);
      repeat (2) u_source.pulse();
      repeat (70) @(posedge clk_sys);
      reg_wr(12'h034, 8'h00);
      rd_chk(12'h036, 8'h00);
      rd_chk(12'h034, 8'h00);
      reg_wr(12'h03A, 8'h00);
      edge_at(16'h001C);
      u_source.start_data();
      rd_chk(12'h302, 8'h09);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      test_registers();
      test_pulse_count();
      test_one_shot();
      test_continuous();
      test_subclass0();
      final_report();
   end

   // Watchdog
   initial begin
      #800000;
      failures++;
      final_report();
   end
endmodule
`default_nettype wire
